/* bench/phs_peer_model.sv */
// Behavioural peripheral answering acknowledge pulses with request pulses
`timescale 1ns/1ps
`default_nettype none
module phs_peer_model (
	input wire logic		hclk,
	input wire logic		rst_n,
	input wire logic		ack_inv,
	input wire logic		req_inv,
	input wire logic [7:0]		lag,
	input wire logic [31:0]		word,
	input wire logic		device_acknowledge,
	input wire logic [31:0]		data_out,
	output logic			peer_request,
	output logic [31:0]		data_in,
	output logic [31:0]		seen_q,
	output logic [7:0]		count_q
);
	logic		ack;
	logic		ack_q;
	logic		req_q;
	logic		busy_q;
	logic [7:0]	t_q;
	// Pins follow the chosen polarity
	assign ack = device_acknowledge ^ ack_inv;
	assign peer_request = req_q ^ req_inv;
	// Word stands only while the strobe is active
	assign data_in = req_q ? word : ~word;
	// Wait for the acknowledge edge, pause, then an 11-cycle request
	always_ff @(posedge hclk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
			req_q <= 1'b0;
			busy_q <= 1'b0;
			t_q <= 8'h0;
			seen_q <= 32'h0;
			count_q <= 8'h0;
		end else begin
			ack_q <= ack;
			if (!busy_q) begin
				busy_q <= ack & ~ack_q;
				t_q <= lag;
			end else if (t_q != 8'h0) begin
				t_q <= t_q - 8'h1;
			end else if (!req_q) begin
				req_q <= 1'b1;
				t_q <= 8'd10;
				seen_q <= data_out;
				count_q <= count_q + 8'h1;
			end else begin
				req_q <= 1'b0;
				busy_q <= 1'b0;
			end
		end
	end
endmodule : phs_peer_model
`default_nettype wire

/* bench/phs_port_checker.sv */
// Pin-level checks of the pulse handshake port
`timescale 1ns/1ps
`default_nettype none
module phs_port_checker #(
	parameter int DW = 32
) (
	input wire logic		hclk,
	input wire logic		hresetn,
	input wire logic		hsel,
	input wire logic [31:0]		haddr,
	input wire logic [1:0]		htrans,
	input wire logic		hwrite,
	input wire logic [31:0]		hwdata,
	input wire logic		hready,
	input wire logic		peer_request,
	input wire logic		device_acknowledge,
	input wire logic [DW-1:0]	data_out
);
	import phs_pkg::*;
	logic		wr_q;
	logic [10:0]	ctl_q;
	logic [15:0]	hi_q;
	logic [15:0]	st_q;
	logic		saw_q;
	logic		ack_a;
	logic		req_a;
	int		lng;
	int		sd;
	// Active-high views of the pins
	assign ack_a = device_acknowledge ^ ctl_q[CTRL_ACK_INV];
	assign req_a = peer_request ^ ctl_q[CTRL_REQ_INV];
	assign lng = ctl_q[CTRL_LONG] ? int'(ctl_q[10:8]) : 0;
	assign sd = ctl_q[CTRL_LONG] ? 0 : int'(ctl_q[10:8]);
	// Shadow of the control register, snooped from bus writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			ctl_q <= CTRL_RESET;
		end else if (hready) begin
			wr_q <= hsel & htrans[1] & hwrite & (haddr[3:0] == REG_CTRL);
			if (wr_q) ctl_q <= hwdata[10:0];
		end
	end
	// Length of the pulse, overlap with a request, age of the output word
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hi_q <= 16'h0;
			saw_q <= 1'b0;
			st_q <= 16'h1;
		end else begin
			hi_q <= ack_a ? hi_q + 16'h1 : 16'h0;
			saw_q <= ack_a & (saw_q | req_a);
			st_q <= $changed(data_out) ? 16'h1 : st_q + 16'h1;
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn || !ctl_q[CTRL_ENABLE]);
	a_ack_min_width: assert property ($fell(ack_a) |->
		int'(hi_q) * CLK_NS >= ACK_MIN_NS + DELAY_STEP_NS * lng)
		else $error("acknowledge pulse too short");
	a_ack_fixed_width: assert property ($fell(ack_a) && !saw_q |->
		int'(hi_q) == int'(ACK_MIN_CYC) + int'(DELAY_STEP_CYC) * lng)
		else $error("acknowledge width not fixed");
	a_ack_tail_hold: assert property ($fell(req_a) && ack_a |->
		ack_a [*8] ##1 ack_a [*8] ##1 ack_a [*3])
		else $error("acknowledge dropped too soon after request");
	a_ack_req_stretch: assert property (req_a [*2] ##0 ack_a |=> ack_a)
		else $error("acknowledge dropped while request active");
	a_out_setup: assert property ($rose(ack_a) && ctl_q[CTRL_DIR_OUT] &&
		!ctl_q[CTRL_LATCH] |-> int'(st_q) * CLK_NS >= SETUP_NS + DELAY_STEP_NS * sd)
		else $error("output data setup too short");
	a_latch_steady: assert property (ctl_q[CTRL_DIR_OUT] && ctl_q[CTRL_LATCH] &&
		req_a && $past(req_a) |-> $stable(data_out))
		else $error("output word moved during request");
	a_long_start: assert property (ctl_q[CTRL_LONG] && ctl_q[CTRL_DIR_OUT] &&
		!ack_a && !req_a && $changed(data_out) |-> ##[1:8] $rose(ack_a))
		else $error("long pulse start was delayed");
	a_idle_level: assert property (disable iff (!hresetn)
		(!ctl_q[CTRL_ENABLE] && $stable(ctl_q)) [*3] |-> !ack_a)
		else $error("acknowledge active while disabled");
endmodule : phs_port_checker
bind phs_port phs_port_checker #(.DW(DW)) u_chk (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .peer_request(peer_request),
	.device_acknowledge(device_acknowledge), .data_out(data_out));
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench of the pulse handshake port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import phs_pkg::*;
	logic		hclk, hresetn, hsel, hwrite, pon, ainv, rinv, hrdy, hresp, ack, req, oe;
	logic [1:0]	htrans;
	logic [2:0]	hsize;
	logic [31:0]	haddr, hwdata, hrdata, word, data_in, data_out, seen, rd;
	logic [7:0]	lag, cnt;
	int		err_count, n_compared, cyc, stl;
	phs_port dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy),
		.hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata), .peer_request(req),
		.device_acknowledge(ack), .data_in(data_in), .data_out(data_out), .data_oe(oe));
	phs_peer_model peer (.hclk(hclk), .rst_n(hresetn & pon), .ack_inv(ainv),
		.req_inv(rinv), .lag(lag), .word(word), .device_acknowledge(ack),
		.data_out(data_out), .peer_request(req), .data_in(data_in), .seen_q(seen),
		.count_q(cnt));
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	// Cut a hang short
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_count++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	// One single bus transfer; read data lands in rd
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {28'h0, a};
		hwrite <= w;
		@(posedge hclk);
		while (hrdy !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		stl = 0;
		@(posedge hclk);
		// Count data-phase wait states so a stalled write can be checked
		while (hrdy !== 1'b1) begin
			stl++;
			@(posedge hclk);
		end
		rd = hrdata;
	endtask : bus
	// Configure while disabled, peer held off during polarity change
	task automatic cfg(input logic [10:0] c, input logic [7:0] l);
		pon <= 1'b0;
		bus(1'b1, REG_CTRL, {21'h0, c});
		ainv <= c[CTRL_ACK_INV];
		rinv <= c[CTRL_REQ_INV];
		lag <= l;
		repeat (3) @(posedge hclk);
		chk(32'(ack), 32'(c[CTRL_ACK_INV]));
		chk(32'(oe), 32'h0);
		pon <= 1'b1;
	endtask : cfg
	task automatic run_out(input logic [10:0] c, input logic [7:0] l, input int n,
		input logic [31:0] b);
		cfg(c, l);
		for (int i = 0; i < n && i < 4; i++) bus(1'b1, REG_TXDATA, b + i);
		if (n > 3) begin
			bus(1'b0, REG_STATUS, 32'h0);
			chk(rd & 32'h723, 32'h402);
		end
		bus(1'b1, REG_CTRL, {21'h0, c | 11'h1});
		for (int i = 4; i < n; i++) bus(1'b1, REG_TXDATA, b + i);
		// The sixth word meets a full FIFO and must wait
		if (n > 5) chk(32'(stl != 0), 32'h1);
		for (int i = 0; i < n; i++) begin
			while (cnt !== 8'(i + 1)) @(posedge hclk);
			chk(seen, b + i);
			if (c[CTRL_LATCH] && i < n - 1) begin
				while ((req ^ rinv) !== 1'b0) @(posedge hclk);
				repeat (5) @(posedge hclk);
				chk(data_out, b + i + 1);
			end
		end
		chk(32'(oe), 32'h1);
		bus(1'b0, REG_STATUS, 32'h0);
		chk(rd & 32'h723, 32'h1);
		$display("Output test done at %0t", $time);
	endtask : run_out
	task automatic run_in(input logic [10:0] c, input int n, input logic [31:0] b);
		cfg(c, 8'h3);
		word <= b;
		bus(1'b1, REG_CTRL, {21'h0, c | 11'h1});
		for (int i = 1; i <= n; i++) begin
			while (cnt !== 8'(i)) @(posedge hclk);
			repeat (2) @(posedge hclk);
			word <= b + i;
		end
		bus(1'b1, REG_CTRL, 32'h0);
		for (int i = 0; i < n; i++) begin
			bus(1'b0, REG_RXDATA, 32'h0);
			chk(rd, b + i);
		end
		$display("Input test done at %0t", $time);
	endtask : run_in
	task automatic tally_and_finish();
		$display("Compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		pon = 1'b0;
		ainv = 1'b0;
		rinv = 1'b0;
		lag = 8'h0;
		word = 32'h0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, REG_CTRL, 32'h0);
		chk(rd, 32'h0);
		chk(32'(hresp), 32'h0);
		bus(1'b0, REG_STATUS, 32'h0);
		chk(rd, 32'h1);
		bus(1'b0, REG_TXDATA, 32'h0);
		chk(rd, 32'h0);
		// Flush empties a FIFO loaded while disabled
		bus(1'b1, REG_CTRL, 32'h2);
		bus(1'b1, REG_TXDATA, 32'h5);
		bus(1'b1, REG_CTRL, 32'h42);
		@(posedge hclk);
		bus(1'b0, REG_STATUS, 32'h0);
		chk(rd & 32'h723, 32'h1);
		$display("Register test done at %0t", $time);
		// Slow peer, full FIFO stalls a write
		run_out(11'h002, 8'd30, 6, 32'ha0);
		// Long pulse, active low, legacy delay code
		run_out({DELAY_LEGACY, 8'h3e}, 8'd0, 3, 32'hb0);
		run_out(11'h70a, 8'd2, 2, 32'hc0);
		run_in(11'h708, 2, 32'hd0);
		run_in(11'h534, 1, 32'he0);
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire

/* design/phs_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module phs_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic                       clear,
	input  wire logic                       in_valid,
	output logic                            in_ready,
	input  wire logic [WIDTH-1:0]           in_data,
	output logic                            out_valid,
	input  wire logic                       out_ready,
	output logic [WIDTH-1:0]                out_data,
	output logic [$clog2(DEPTH+1)-1:0]      level
);
	localparam int AW = $clog2(DEPTH);
	localparam int LW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [LW-1:0]    cnt_q;
	logic             push;
	logic             pop;

	// Honest full and empty from the count
	assign in_ready  = (cnt_q != LW'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem[rd_q];
	assign level     = cnt_q;
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end

	// Pointers and count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else if (clear) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + LW'(push) - LW'(pop);
		end
	end

endmodule : phs_fifo
`default_nettype wire

/* design/phs_port.sv */
// Pulse handshake port: AHB-Lite registers, FIFO and handshake engine
//
// Chosen here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module phs_port #(
	parameter int DW    = 32,
	parameter int DEPTH = 4
) (
	input  wire logic          hclk,
	input  wire logic          hresetn,
	input  wire logic          hsel,
	input  wire logic [31:0]   haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [2:0]    hsize,
	input  wire logic [31:0]   hwdata,
	input  wire logic          hready,
	output logic               hreadyout,
	output logic               hresp,
	output logic [31:0]        hrdata,
	input  wire logic          peer_request,
	output logic               device_acknowledge,
	input  wire logic [DW-1:0] data_in,
	output logic [DW-1:0]      data_out,
	output logic               data_oe
);
	import phs_pkg::*;

	localparam int LW = $clog2(DEPTH + 1);

	// ****************************************
	// Declarations
	// ****************************************
	phs_ctrl_t        ctrl_q;
	phs_state_t       state_q;
	logic [7:0]       cnt_q;
	logic [31:0]      hrdata_q;
	logic             wr_ph_q;
	logic [3:0]       wr_addr_q;
	logic             flush_q;
	logic             ack_q;
	logic             ack_pin_q;
	logic             req_prev_q;
	logic             req_seen_q;
	logic             loaded_q;
	logic [DW-1:0]    dout_q;
	logic             req;
	logic             req_rise;
	logic             req_fall;
	logic             acc;
	logic             tx_wr;
	logic             rx_rd;
	logic             f_in_valid;
	logic             f_in_ready;
	logic [DW-1:0]    f_in_data;
	logic             f_out_valid;
	logic             f_out_ready;
	logic [DW-1:0]    f_out_data;
	logic [LW-1:0]    f_level;
	logic             load_ok;
	logic             load;
	logic             capture;
	logic [7:0]       dly_cyc;
	logic [7:0]       setup_cyc;
	logic [7:0]       width_cyc;

	// ****************************************
	// Pin polarity
	// ****************************************
	// Internal logic sees active-high lines only
	assign req                = peer_request ^ ctrl_q.req_inv;
	assign device_acknowledge = ack_pin_q;
	assign req_rise           = req & ~req_prev_q;
	assign req_fall           = ~req & req_prev_q;

	// Acknowledge pin registered after inversion
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ack_pin_q <= 1'b0;
		end else begin
			ack_pin_q <= ack_q ^ ctrl_q.ack_inv;
		end
	end

	// Previous request level for edge detection
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_prev_q <= 1'b0;
		end else begin
			req_prev_q <= req;
		end
	end

	// ****************************************
	// AHB-Lite slave
	// ****************************************
	assign acc       = hsel & htrans[1] & hready;
	assign rx_rd     = acc & ~hwrite & (haddr[3:0] == REG_RXDATA) & ~ctrl_q.dir_out;
	assign tx_wr     = wr_ph_q & (wr_addr_q == REG_TXDATA) & ctrl_q.dir_out;
	// Stall a transmit write while the FIFO is full
	assign hreadyout = ~(tx_wr & ~f_in_ready);
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;

	// Write data phase tracking
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ph_q   <= 1'b0;
			wr_addr_q <= '0;
		end else if (hreadyout) begin
			wr_ph_q   <= acc & hwrite;
			wr_addr_q <= haddr[3:0];
		end
	end

	// Control register write; flush is a one-cycle pulse
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q  <= phs_ctrl_t'(CTRL_RESET);
			flush_q <= 1'b0;
		end else begin
			flush_q <= 1'b0;
			if (wr_ph_q && wr_addr_q == REG_CTRL) begin
				ctrl_q.enable     <= hwdata[CTRL_ENABLE];
				ctrl_q.dir_out    <= hwdata[CTRL_DIR_OUT];
				ctrl_q.long_pulse <= hwdata[CTRL_LONG];
				ctrl_q.edge_latch <= hwdata[CTRL_LATCH];
				ctrl_q.req_inv    <= hwdata[CTRL_REQ_INV];
				ctrl_q.ack_inv    <= hwdata[CTRL_ACK_INV];
				ctrl_q.delay      <= hwdata[CTRL_DLY_LSB +: 3];
				flush_q           <= hwdata[CTRL_FLUSH];
			end
		end
	end

	// Read data captured in the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= '0;
		end else if (acc && !hwrite) begin
			hrdata_q <= '0;
			if (haddr[3:0] == REG_CTRL) begin
				hrdata_q[CTRL_ENABLE]        <= ctrl_q.enable;
				hrdata_q[CTRL_DIR_OUT]       <= ctrl_q.dir_out;
				hrdata_q[CTRL_LONG]          <= ctrl_q.long_pulse;
				hrdata_q[CTRL_LATCH]         <= ctrl_q.edge_latch;
				hrdata_q[CTRL_REQ_INV]       <= ctrl_q.req_inv;
				hrdata_q[CTRL_ACK_INV]       <= ctrl_q.ack_inv;
				hrdata_q[CTRL_DLY_LSB +: 3]  <= ctrl_q.delay;
			end else if (haddr[3:0] == REG_STATUS) begin
				hrdata_q[STAT_EMPTY]         <= ~f_out_valid;
				hrdata_q[STAT_FULL]          <= ~f_in_ready;
				hrdata_q[STAT_BUSY]          <= (state_q != ST_IDLE);
				hrdata_q[STAT_ACK]           <= ack_q;
				hrdata_q[STAT_REQ]           <= req;
				hrdata_q[STAT_LOADED]        <= loaded_q;
				hrdata_q[STAT_LVL_LSB +: LW] <= f_level;
			end else if (rx_rd && f_out_valid) begin
				hrdata_q[DW-1:0]             <= f_out_data;
			end
		end
	end

	// ****************************************
	// Data FIFO, shared by both directions
	// ****************************************
	assign f_in_valid  = ctrl_q.dir_out ? tx_wr : capture;
	assign f_in_data   = ctrl_q.dir_out ? hwdata[DW-1:0] : data_in;
	assign f_out_ready = ctrl_q.dir_out ? load : rx_rd;

	phs_fifo #(
		.WIDTH (DW),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk       (hclk),
		.rst_n     (hresetn),
		.clear     (flush_q),
		.in_valid  (f_in_valid),
		.in_ready  (f_in_ready),
		.in_data   (f_in_data),
		.out_valid (f_out_valid),
		.out_ready (f_out_ready),
		.out_data  (f_out_data),
		.level     (f_level)
	);

	// ****************************************
	// Output word staging
	// ****************************************
	// Next word as soon as request rises, or only once it is inactive
	assign load_ok = ctrl_q.edge_latch ? ~req : 1'b1;
	assign load    = ctrl_q.dir_out & ctrl_q.enable & ~loaded_q & f_out_valid & load_ok;
	assign data_out = dout_q;
	assign data_oe  = ctrl_q.dir_out & ctrl_q.enable;

	// Output data register and its loaded flag
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dout_q   <= '0;
			loaded_q <= 1'b0;
		end else if (flush_q || !ctrl_q.dir_out) begin
			loaded_q <= 1'b0;
		end else if (load) begin
			dout_q   <= f_out_data;
			loaded_q <= 1'b1;
		end else if (capture) begin
			loaded_q <= 1'b0;
		end
	end

	// ****************************************
	// Handshake engine
	// ****************************************
	// Transfer happens on the first request edge after acknowledge rose
	assign capture = req_rise & ~req_seen_q & ctrl_q.enable
		& ((state_q == ST_ACK) | (state_q == ST_WAIT));

	// Delay, setup and pulse width for the current mode
	assign dly_cyc   = 8'(ctrl_q.delay * DELAY_STEP_CYC);
	always_comb begin
		if (ctrl_q.long_pulse) begin
			setup_cyc = ctrl_q.dir_out ? SETUP_CYC : 8'h01;
			width_cyc = ACK_MIN_CYC + dly_cyc;
		end else begin
			setup_cyc = ctrl_q.dir_out ? SETUP_CYC + dly_cyc : dly_cyc;
			width_cyc = ACK_MIN_CYC;
		end
		if (setup_cyc == 8'h00) begin
			setup_cyc = 8'h01;
		end
	end

	// State, counter, acknowledge and request tracking
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q    <= ST_IDLE;
			cnt_q      <= '0;
			ack_q      <= 1'b0;
			req_seen_q <= 1'b0;
		end else if (!ctrl_q.enable || flush_q) begin
			state_q    <= ST_IDLE;
			ack_q      <= 1'b0;
			req_seen_q <= 1'b0;
		end else begin
			if (capture) begin
				req_seen_q <= 1'b1;
			end
			case (state_q)
				ST_IDLE: begin
					req_seen_q <= 1'b0;
					if (ctrl_q.dir_out ? loaded_q : f_in_ready) begin
						cnt_q   <= setup_cyc - 8'h01;
						state_q <= ST_SETUP;
					end
				end
				ST_SETUP: begin
					if (cnt_q == 8'h00) begin
						cnt_q   <= width_cyc - 8'h01;
						ack_q   <= 1'b1;
						state_q <= ST_ACK;
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				ST_ACK: begin
					if (cnt_q != 8'h00) begin
						cnt_q <= cnt_q - 8'h01;
					end else if (req_fall && req_seen_q) begin
						cnt_q   <= REQ_OFF_CYC - 8'h01;
						state_q <= ST_TAIL;
					end else if (!req) begin
						ack_q   <= 1'b0;
						state_q <= req_seen_q ? ST_IDLE : ST_WAIT;
					end
					if (cnt_q != 8'h00 && req_fall && req_seen_q) begin
						cnt_q <= (cnt_q > REQ_OFF_CYC - 8'h01) ? cnt_q - 8'h01
							: REQ_OFF_CYC - 8'h01;
					end
				end
				ST_TAIL: begin
					if (req) begin
						cnt_q <= REQ_OFF_CYC - 8'h01;
					end else if (cnt_q == 8'h00) begin
						ack_q   <= 1'b0;
						state_q <= ST_IDLE;
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				ST_WAIT: begin
					if (req_seen_q && !req) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

endmodule : phs_port
`default_nettype wire

/* pkg/phs_pkg.sv */
// Constants, register map and types of the pulse handshake port
package phs_pkg;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [3:0] REG_CTRL    = 4'h0;
	localparam logic [3:0] REG_STATUS  = 4'h4;
	localparam logic [3:0] REG_TXDATA  = 4'h8;
	localparam logic [3:0] REG_RXDATA  = 4'hc;

	// Control field positions
	localparam int CTRL_ENABLE   = 0;
	localparam int CTRL_DIR_OUT  = 1;
	localparam int CTRL_LONG     = 2;
	localparam int CTRL_LATCH    = 3;
	localparam int CTRL_REQ_INV  = 4;
	localparam int CTRL_ACK_INV  = 5;
	localparam int CTRL_FLUSH    = 6;
	localparam int CTRL_DLY_LSB  = 8;

	// Status field positions
	localparam int STAT_EMPTY    = 0;
	localparam int STAT_FULL     = 1;
	localparam int STAT_BUSY     = 2;
	localparam int STAT_ACK      = 3;
	localparam int STAT_REQ      = 4;
	localparam int STAT_LOADED   = 5;
	localparam int STAT_LVL_LSB  = 8;

	// Control reset value: disabled, input, leading-edge, active high
	localparam logic [10:0] CTRL_RESET = 11'h000;
	// Delay code for 500 ns settling toward a legacy interface
	localparam logic [2:0] DELAY_LEGACY = 3'h5;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_NS        = 8;
	localparam int ACK_MIN_NS    = 125;
	localparam int SETUP_NS      = 25;
	localparam int DELAY_STEP_NS = 100;
	localparam int REQ_OFF_NS    = 150;
	localparam int NEXT_DATA_NS  = 50;
	localparam logic [7:0] ACK_MIN_CYC    = 8'((ACK_MIN_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] SETUP_CYC      = 8'((SETUP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] DELAY_STEP_CYC = 8'((DELAY_STEP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] REQ_OFF_CYC    = 8'((REQ_OFF_NS + CLK_NS - 1) / CLK_NS);
	// Longest allowed lag of the next word, for reference by checks
	localparam logic [7:0] NEXT_DATA_CYC  = 8'(NEXT_DATA_NS / CLK_NS);

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic [2:0] delay;
		logic       ack_inv;
		logic       req_inv;
		logic       edge_latch;
		logic       long_pulse;
		logic       dir_out;
		logic       enable;
	} phs_ctrl_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_ACK,
		ST_TAIL,
		ST_WAIT
	} phs_state_t;

endpackage : phs_pkg
